// ### logic/cdsc_pkg.sv
// cdsc_pkg: constants and carrier types for the card dma slave channel
// assumes an 8-bit i/o register port decoded on a 4-bit offset from the dma base
// Overview of operation
// - middle count register holds count bits 15:8, read/write, resets to zero
// - top count byte is used only when extended addressing is enabled
// - with top byte enabled, transfer count may exceed sixteen bits
// - command/status bits 3:0 read back the terminal-count flag
// - command bit 2 disables all dma transfers while set
// - command/status bits 7:4 read the inverted card request line
// - request register reads zero; only the software request bit acts
// - in block mode, writing request bit 2 starts transfers without card request
// - mode register reads back the last value written
// - channel field mode bits 1:0 has no effect but reads back
// - mode bits 3:2 select verify, dma write, dma read; 11 reserved
// - autoinitialize reloads current count from base count at completion
// - mode bit 5 makes addresses step downward, else upward
// - mode bits 7:6 select demand, single, block; cascade not implemented
// - any master-clear write resets the dma section, not the window config
// - master-clear register returns no meaningful read data
// - mask bit 0 set ignores card requests; clear honours them
// - completion without autoinitialize sets the mask bit
// - mask register covers one channel and is readable
// - count decrements per transaction through zero and one more
package cdsc_pkg;
   localparam logic [3:0] CDSC_OFS_COUNT_LOW = 4'h4;
   localparam logic [3:0] CDSC_OFS_COUNT_MID = 4'h5;
   localparam logic [3:0] CDSC_OFS_COUNT_TOP = 4'h6;
   localparam logic [3:0] CDSC_OFS_CMD_STAT = 4'h8;
   localparam logic [3:0] CDSC_OFS_SW_REQ = 4'h9;
   localparam logic [3:0] CDSC_OFS_MODE = 4'hb;
   localparam logic [3:0] CDSC_OFS_CLEAR = 4'hd;
   localparam logic [3:0] CDSC_OFS_MASK = 4'hf;
   localparam logic [7:0] CDSC_RST_BYTE = 8'h00;
   localparam logic [23:0] CDSC_RST_COUNT = 24'h000000;
   localparam logic CDSC_RST_MASK = 1'b0;
   localparam int CDSC_CMD_DISABLE_BIT = 2;
   localparam int CDSC_REQ_SET_BIT = 2;
   localparam int CDSC_CFG_EXT_BIT = 3;
   localparam int CDSC_MASK_BIT = 0;
   localparam logic [1:0] CDSC_XFER_VERIFY = 2'h0;
   localparam logic [1:0] CDSC_XFER_WRITE = 2'h1;
   localparam logic [1:0] CDSC_XFER_READ = 2'h2;
   localparam logic [1:0] CDSC_REQ_DEMAND = 2'h0;
   localparam logic [1:0] CDSC_REQ_SINGLE = 2'h1;
   localparam logic [1:0] CDSC_REQ_BLOCK = 2'h2;

   typedef struct packed {
      logic [1:0] req_mode;
      logic addr_down;
      logic auto_init;
      logic [1:0] xfer_mode;
      logic [1:0] channel;
   } cdsc_mode_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [3:0] ofs;
      logic [7:0] wdata;
   } cdsc_reg_req_t;

   typedef enum logic [1:0] {
      CDSC_IDLE,
      CDSC_RUN
   } cdsc_state_t;
endpackage

// ### logic/cdsc_channel.sv
// cdsc_channel: one dma slave channel with its i/o register file
// assumes register accesses are single-cycle strobes on clk_sys_i; each
// transaction done by the card side is one xfer_done_i pulse
`timescale 1ns/1ps
`default_nettype none
module cdsc_channel (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic reset_i,
   // register port
   input wire cdsc_pkg::cdsc_reg_req_t reg_req_i,
   output logic [7:0] reg_rdata_o,
   // window configuration, held outside this block
   input wire logic [7:0] window_cfg_i,
   // card side
   input wire logic card_req_i,
   input wire logic xfer_done_i,
   output logic xfer_go_o,
   output logic [1:0] xfer_type_o,
   output logic addr_down_o,
   output logic terminal_count_o
);
   cdsc_pkg::cdsc_mode_t mode_r;
   cdsc_pkg::cdsc_state_t state_r;
   logic [23:0] base_count_r;
   logic [23:0] cur_count_r;
   logic [7:0] cmd_r;
   logic mask_r;
   logic tc_r;
   logic sw_req_r;
   logic clear_w;
   logic ext_w;
   logic last_w;
   logic enabled_w;
   logic want_w;
   logic start_w;
   logic [7:0] rdata_nxt;

   assign clear_w = reset_i | (reg_req_i.wr && reg_req_i.ofs == cdsc_pkg::CDSC_OFS_CLEAR);
   assign ext_w = window_cfg_i[cdsc_pkg::CDSC_CFG_EXT_BIT];
   // count of zero ends one further step: bits 15:0 wrap to all ones past zero
   assign last_w = ext_w ? (cur_count_r == 24'h000000)
                         : (cur_count_r[15:0] == 16'h0000);
   assign enabled_w = !cmd_r[cdsc_pkg::CDSC_CMD_DISABLE_BIT];
   assign want_w = (card_req_i && !mask_r) || sw_req_r;
   // cascade never starts a run, so it must not clear terminal count either
   assign start_w = want_w && enabled_w && mode_r.req_mode != 2'h3;

   // mode register, channel bits stored but unused
   always_ff @(posedge clk_sys_i) begin
      if (clear_w) begin
         mode_r <= '0;
      end else if (reg_req_i.wr && reg_req_i.ofs == cdsc_pkg::CDSC_OFS_MODE) begin
         mode_r <= reg_req_i.wdata;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (clear_w) begin
         cmd_r <= cdsc_pkg::CDSC_RST_BYTE;
      end else if (reg_req_i.wr && reg_req_i.ofs == cdsc_pkg::CDSC_OFS_CMD_STAT) begin
         cmd_r <= reg_req_i.wdata;
      end
   end

   // base and current count; writes load both, as on the classic part
   always_ff @(posedge clk_sys_i) begin
      if (clear_w) begin
         base_count_r <= cdsc_pkg::CDSC_RST_COUNT;
         cur_count_r <= cdsc_pkg::CDSC_RST_COUNT;
      end else if (reg_req_i.wr && reg_req_i.ofs == cdsc_pkg::CDSC_OFS_COUNT_LOW) begin
         base_count_r[7:0] <= reg_req_i.wdata;
         cur_count_r[7:0] <= reg_req_i.wdata;
      end else if (reg_req_i.wr && reg_req_i.ofs == cdsc_pkg::CDSC_OFS_COUNT_MID) begin
         base_count_r[15:8] <= reg_req_i.wdata;
         cur_count_r[15:8] <= reg_req_i.wdata;
      end else if (reg_req_i.wr && reg_req_i.ofs == cdsc_pkg::CDSC_OFS_COUNT_TOP) begin
         base_count_r[23:16] <= reg_req_i.wdata;
         cur_count_r[23:16] <= reg_req_i.wdata;
      end else if (state_r == cdsc_pkg::CDSC_RUN && xfer_done_i) begin
         if (last_w && mode_r.auto_init) begin
            cur_count_r <= base_count_r;
         end else begin
            cur_count_r <= cur_count_r - 24'h000001;
         end
      end
   end

   // software request latches until terminal count; only bit 2 acts
   always_ff @(posedge clk_sys_i) begin
      if (clear_w) begin
         sw_req_r <= 1'b0;
      end else if (reg_req_i.wr && reg_req_i.ofs == cdsc_pkg::CDSC_OFS_SW_REQ) begin
         sw_req_r <= reg_req_i.wdata[cdsc_pkg::CDSC_REQ_SET_BIT]
                     && mode_r.req_mode == cdsc_pkg::CDSC_REQ_BLOCK;
      end else if (state_r == cdsc_pkg::CDSC_RUN && xfer_done_i && last_w) begin
         sw_req_r <= 1'b0;
      end
   end

   // hardware set of mask wins over a same-cycle software write
   always_ff @(posedge clk_sys_i) begin
      if (clear_w) begin
         mask_r <= cdsc_pkg::CDSC_RST_MASK;
      end else if (state_r == cdsc_pkg::CDSC_RUN && xfer_done_i && last_w && !mode_r.auto_init) begin
         mask_r <= 1'b1;
      end else if (reg_req_i.wr && reg_req_i.ofs == cdsc_pkg::CDSC_OFS_MASK) begin
         mask_r <= reg_req_i.wdata[cdsc_pkg::CDSC_MASK_BIT];
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (clear_w) begin
         tc_r <= 1'b0;
      end else if (state_r == cdsc_pkg::CDSC_RUN && xfer_done_i && last_w) begin
         tc_r <= 1'b1;
      end else if (state_r == cdsc_pkg::CDSC_IDLE && start_w) begin
         tc_r <= 1'b0;
      end
   end

   // run control: demand drops on request loss, single gives up after each beat
   always_ff @(posedge clk_sys_i) begin
      if (clear_w) begin
         state_r <= cdsc_pkg::CDSC_IDLE;
      end else begin
         unique case (state_r)
            cdsc_pkg::CDSC_IDLE: begin
               if (start_w) begin
                  state_r <= cdsc_pkg::CDSC_RUN;
               end
            end
            cdsc_pkg::CDSC_RUN: begin
               if (!enabled_w) begin
                  state_r <= cdsc_pkg::CDSC_IDLE;
               end else if (xfer_done_i && (last_w || mode_r.req_mode == cdsc_pkg::CDSC_REQ_SINGLE)) begin
                  state_r <= cdsc_pkg::CDSC_IDLE;
               end else if (mode_r.req_mode == cdsc_pkg::CDSC_REQ_DEMAND && !want_w) begin
                  state_r <= cdsc_pkg::CDSC_IDLE;
               end
            end
            default: state_r <= cdsc_pkg::CDSC_IDLE;
         endcase
      end
   end

   assign xfer_go_o = state_r == cdsc_pkg::CDSC_RUN && enabled_w;
   assign xfer_type_o = mode_r.xfer_mode;
   assign addr_down_o = mode_r.addr_down;
   assign terminal_count_o = tc_r;

   always_comb begin
      rdata_nxt = 8'h00;
      unique case (reg_req_i.ofs)
         cdsc_pkg::CDSC_OFS_COUNT_LOW: rdata_nxt = cur_count_r[7:0];
         cdsc_pkg::CDSC_OFS_COUNT_MID: rdata_nxt = cur_count_r[15:8];
         cdsc_pkg::CDSC_OFS_COUNT_TOP: rdata_nxt = cur_count_r[23:16];
         cdsc_pkg::CDSC_OFS_CMD_STAT: rdata_nxt = {{4{!card_req_i}}, {4{tc_r}}};
         cdsc_pkg::CDSC_OFS_MODE: rdata_nxt = mode_r;
         cdsc_pkg::CDSC_OFS_MASK: rdata_nxt = {7'h00, mask_r};
         default: rdata_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_req_i.rd) begin
         reg_rdata_o <= rdata_nxt;
      end
   end

   a_mask_on_done: assert property (@(posedge clk_sys_i) disable iff (clear_w)
      state_r == cdsc_pkg::CDSC_RUN && xfer_done_i && last_w && !mode_r.auto_init
      |=> mask_r)
      else $error("mask not set at completion");
   a_disable_blocks: assert property (@(posedge clk_sys_i) disable iff (clear_w)
      cmd_r[cdsc_pkg::CDSC_CMD_DISABLE_BIT]
      |-> !xfer_go_o ##1 state_r == cdsc_pkg::CDSC_IDLE)
      else $error("transfer while disabled");
   a_tc_raise: assert property (@(posedge clk_sys_i) disable iff (clear_w)
      state_r == cdsc_pkg::CDSC_RUN && xfer_done_i && last_w
      |=> tc_r)
      else $error("terminal count not raised");
   a_tc_hold: assert property (@(posedge clk_sys_i) disable iff (clear_w)
      tc_r && !(state_r == cdsc_pkg::CDSC_IDLE && start_w)
      |=> tc_r)
      else $error("terminal count lost");
   a_auto_reload: assert property (@(posedge clk_sys_i) disable iff (clear_w)
      state_r == cdsc_pkg::CDSC_RUN && xfer_done_i && last_w && mode_r.auto_init
      && !reg_req_i.wr |=> cur_count_r == $past(base_count_r))
      else $error("count not reloaded");
   a_auto_keeps_mask: assert property (@(posedge clk_sys_i) disable iff (clear_w)
      state_r == cdsc_pkg::CDSC_RUN && xfer_done_i && last_w && mode_r.auto_init
      && !reg_req_i.wr |=> $stable(mask_r))
      else $error("mask changed on reload");
   a_count_step: assert property (@(posedge clk_sys_i) disable iff (clear_w)
      state_r == cdsc_pkg::CDSC_RUN && xfer_done_i && !last_w && !reg_req_i.wr
      |=> cur_count_r == $past(cur_count_r) - 24'h000001)
      else $error("count did not step");
   a_short_count: assert property (@(posedge clk_sys_i) disable iff (clear_w)
      state_r == cdsc_pkg::CDSC_RUN && xfer_done_i && !ext_w && cur_count_r[15:0] == 16'h0000
      |=> tc_r)
      else $error("short count did not end");
   a_long_count: assert property (@(posedge clk_sys_i) disable iff (clear_w)
      state_r == cdsc_pkg::CDSC_RUN && xfer_done_i && ext_w && cur_count_r[23:16] != 8'h00
      |=> !tc_r)
      else $error("top count byte ignored");

   a_mid_write: assert property (@(posedge clk_sys_i) disable iff (clear_w)
      reg_req_i.wr && reg_req_i.ofs == cdsc_pkg::CDSC_OFS_COUNT_MID
      |=> base_count_r[15:8] == $past(reg_req_i.wdata) && cur_count_r[15:8] == $past(reg_req_i.wdata))
      else $error("middle count write lost");
   a_mid_read: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      reg_req_i.rd && reg_req_i.ofs == cdsc_pkg::CDSC_OFS_COUNT_MID
      |=> reg_rdata_o == $past(cur_count_r[15:8]))
      else $error("middle count read wrong");
   a_top_write: assert property (@(posedge clk_sys_i) disable iff (clear_w)
      reg_req_i.wr && reg_req_i.ofs == cdsc_pkg::CDSC_OFS_COUNT_TOP
      |=> base_count_r[23:16] == $past(reg_req_i.wdata))
      else $error("top count write lost");
   a_top_read: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      reg_req_i.rd && reg_req_i.ofs == cdsc_pkg::CDSC_OFS_COUNT_TOP
      |=> reg_rdata_o == $past(cur_count_r[23:16]))
      else $error("top count read wrong");
   a_status_read: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      reg_req_i.rd && reg_req_i.ofs == cdsc_pkg::CDSC_OFS_CMD_STAT
      |=> reg_rdata_o[3:0] == {4{$past(tc_r)}})
      else $error("status count bits wrong");
   a_request_sense: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      reg_req_i.rd && reg_req_i.ofs == cdsc_pkg::CDSC_OFS_CMD_STAT
      |=> reg_rdata_o[7:4] == {4{!$past(card_req_i)}})
      else $error("status request bits wrong");
   a_mode_write: assert property (@(posedge clk_sys_i) disable iff (clear_w)
      reg_req_i.wr && reg_req_i.ofs == cdsc_pkg::CDSC_OFS_MODE
      |=> mode_r == $past(reg_req_i.wdata))
      else $error("mode write lost");
   a_mode_read: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      reg_req_i.rd && reg_req_i.ofs == cdsc_pkg::CDSC_OFS_MODE
      |=> reg_rdata_o == $past(mode_r))
      else $error("mode read wrong");
   a_type_follow: assert property (@(posedge clk_sys_i) disable iff (clear_w)
      reg_req_i.wr && reg_req_i.ofs == cdsc_pkg::CDSC_OFS_MODE
      |=> xfer_type_o == $past(reg_req_i.wdata[3:2]))
      else $error("transfer type wrong");
   a_addr_dir: assert property (@(posedge clk_sys_i) disable iff (clear_w)
      reg_req_i.wr && reg_req_i.ofs == cdsc_pkg::CDSC_OFS_MODE
      |=> addr_down_o == $past(reg_req_i.wdata[5]))
      else $error("address direction wrong");

   a_no_cascade: assert property (@(posedge clk_sys_i) disable iff (clear_w)
      state_r == cdsc_pkg::CDSC_IDLE && mode_r.req_mode == 2'h3
      |=> state_r == cdsc_pkg::CDSC_IDLE)
      else $error("cascade mode started run");
   a_single_ends: assert property (@(posedge clk_sys_i) disable iff (clear_w)
      state_r == cdsc_pkg::CDSC_RUN && xfer_done_i && mode_r.req_mode == cdsc_pkg::CDSC_REQ_SINGLE
      |=> state_r == cdsc_pkg::CDSC_IDLE)
      else $error("single mode kept running");
   a_demand_drop: assert property (@(posedge clk_sys_i) disable iff (clear_w)
      state_r == cdsc_pkg::CDSC_RUN && mode_r.req_mode == cdsc_pkg::CDSC_REQ_DEMAND && !want_w
      |=> state_r == cdsc_pkg::CDSC_IDLE)
      else $error("demand mode kept running");
   a_block_holds: assert property (@(posedge clk_sys_i) disable iff (clear_w)
      state_r == cdsc_pkg::CDSC_RUN && enabled_w && mode_r.req_mode == cdsc_pkg::CDSC_REQ_BLOCK
      && !xfer_done_i |=> state_r == cdsc_pkg::CDSC_RUN)
      else $error("block mode stopped early");
   a_sw_block_only: assert property (@(posedge clk_sys_i) disable iff (clear_w)
      reg_req_i.wr && reg_req_i.ofs == cdsc_pkg::CDSC_OFS_SW_REQ && mode_r.req_mode != cdsc_pkg::CDSC_REQ_BLOCK
      |=> !sw_req_r)
      else $error("software request outside block mode");
   a_sw_start: assert property (@(posedge clk_sys_i) disable iff (clear_w)
      state_r == cdsc_pkg::CDSC_IDLE && sw_req_r && enabled_w && mode_r.req_mode == cdsc_pkg::CDSC_REQ_BLOCK
      |=> state_r == cdsc_pkg::CDSC_RUN)
      else $error("software request did not start");
   a_masked_idle: assert property (@(posedge clk_sys_i) disable iff (clear_w)
      state_r == cdsc_pkg::CDSC_IDLE && mask_r && !sw_req_r
      |=> state_r == cdsc_pkg::CDSC_IDLE)
      else $error("masked request started run");
   a_mask_write: assert property (@(posedge clk_sys_i) disable iff (clear_w)
      reg_req_i.wr && reg_req_i.ofs == cdsc_pkg::CDSC_OFS_MASK && !(state_r == cdsc_pkg::CDSC_RUN && xfer_done_i)
      |=> mask_r == $past(reg_req_i.wdata[cdsc_pkg::CDSC_MASK_BIT]))
      else $error("mask write lost");
   a_mask_read: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      reg_req_i.rd && reg_req_i.ofs == cdsc_pkg::CDSC_OFS_MASK
      |=> reg_rdata_o == {7'h00, $past(mask_r)})
      else $error("mask read wrong");
   a_clear_resets: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      reg_req_i.wr && reg_req_i.ofs == cdsc_pkg::CDSC_OFS_CLEAR |=> !tc_r && !mask_r && !sw_req_r
      && cur_count_r == cdsc_pkg::CDSC_RST_COUNT && mode_r == '0 && state_r == cdsc_pkg::CDSC_IDLE)
      else $error("master clear incomplete");
   a_clear_read: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      reg_req_i.rd && reg_req_i.ofs == cdsc_pkg::CDSC_OFS_CLEAR
      |=> reg_rdata_o == 8'h00)
      else $error("master clear read not empty");
   a_req_read: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      reg_req_i.rd && reg_req_i.ofs == cdsc_pkg::CDSC_OFS_SW_REQ
      |=> reg_rdata_o == 8'h00)
      else $error("request read not empty");

   c_block_sw: cover property (@(posedge clk_sys_i) sw_req_r && xfer_go_o);
   c_tc_hit: cover property (@(posedge clk_sys_i) $rose(tc_r));
   c_auto: cover property (@(posedge clk_sys_i) xfer_done_i && last_w && mode_r.auto_init);
   c_single_beat: cover property (@(posedge clk_sys_i)
      state_r == cdsc_pkg::CDSC_RUN && xfer_done_i && mode_r.req_mode == cdsc_pkg::CDSC_REQ_SINGLE);
   c_long_count: cover property (@(posedge clk_sys_i) ext_w && xfer_done_i && cur_count_r[23:16] != 8'h00);
endmodule
`default_nettype wire

// ### testbench/cdsc_card_model.sv
// cdsc_card_model: card side of one dma channel, request line and transfer engine
// assumes the bench sets the request level and the pace; done pulses only while go is high
`timescale 1ns/1ps
`default_nettype none
module cdsc_card_model (
   // clock
   input wire logic clk_sys_i,
   // bench control
   input wire logic req_on_i,
   input wire logic slow_i,
   // channel side
   input wire logic xfer_go_i,
   output logic card_req_o,
   output var logic xfer_done_o
);
   assign card_req_o = req_on_i;
   initial xfer_done_o = 1'b0;
   // slow pace leaves a gap cycle between transactions
   always @(negedge clk_sys_i) begin
      xfer_done_o <= xfer_go_i && !(slow_i && xfer_done_o);
   end
endmodule
`default_nettype wire

// ### testbench/card_dma_slave_channel_tb.sv
// card_dma_slave_channel_tb: self-checking bench for the dma slave channel
// assumes 100 MHz clock; inputs change at the falling edge; reads checked from a queue
`timescale 1ns/1ps
`default_nettype none
module card_dma_slave_channel_tb;
   localparam logic [3:0] LO = cdsc_pkg::CDSC_OFS_COUNT_LOW;
   localparam logic [3:0] MID = cdsc_pkg::CDSC_OFS_COUNT_MID;
   localparam logic [3:0] CS = cdsc_pkg::CDSC_OFS_CMD_STAT;
   localparam logic [3:0] MD = cdsc_pkg::CDSC_OFS_MODE;
   localparam logic [3:0] MK = cdsc_pkg::CDSC_OFS_MASK;
   logic clk_sys_i = 1'b0;
   logic reset_i = 1'b1;
   cdsc_pkg::cdsc_reg_req_t req = '0;
   logic [7:0] rdata, m;
   logic [7:0] cfg = 8'h00;
   logic req_on = 1'b0;
   logic slow = 1'b0;
   logic card_req, done, go, adn, tc, rd_seen;
   logic [1:0] xt;
   logic [7:0] exp_q[$];
   int bad_count = 0;
   int n_compared = 0;
   int n_done = 0;
   int seed = 32'h0bdae13e;
   cdsc_channel i_dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .reg_req_i(req), .reg_rdata_o(rdata),
      .window_cfg_i(cfg), .card_req_i(card_req), .xfer_done_i(done), .xfer_go_o(go), .xfer_type_o(xt),
      .addr_down_o(adn), .terminal_count_o(tc));
   cdsc_card_model i_card (.clk_sys_i(clk_sys_i), .req_on_i(req_on), .slow_i(slow), .xfer_go_i(go),
      .card_req_o(card_req), .xfer_done_o(done));
   initial begin
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic final_report;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic wr(input logic [3:0] o, input logic [7:0] d);
      @(negedge clk_sys_i);
      req <= '{wr: 1'b1, rd: 1'b0, ofs: o, wdata: d};
      @(negedge clk_sys_i);
      req <= '0;
   endtask
   task automatic rd(input logic [3:0] o, input logic [7:0] e);
      exp_q.push_back(e);
      @(negedge clk_sys_i);
      req <= '{wr: 1'b0, rd: 1'b1, ofs: o, wdata: 8'h00};
      @(negedge clk_sys_i);
      req <= '0;
   endtask
   // bounded wait, a hang counts as a mismatch
   task automatic wait_go(input logic v);
      int k;
      k = 0;
      while (go !== v && k < 100) begin
         @(negedge clk_sys_i);
         k++;
      end
      if (k == 100) bad_count++;
   endtask
   task automatic go_idle(input int n);
      repeat (n) begin
         @(negedge clk_sys_i);
         check({7'h00, go}, 8'h00);
      end
   endtask
   always @(posedge clk_sys_i) rd_seen <= req.rd;
   always @(posedge clk_sys_i) if (done === 1'b1) n_done++;
   always @(negedge clk_sys_i) if (rd_seen === 1'b1) check(rdata, exp_q.pop_front());
   initial begin
      repeat (10) @(negedge clk_sys_i);
      reset_i <= 1'b0;
      rd(MID, 8'h00);
      rd(MK, 8'h00);
      wr(MID, 8'h5a);
      rd(MID, 8'h5a);
      wr(MK, 8'h01);
      for (int i = 0; i < 6; i++) begin
         m = 8'($random(seed));
         wr(MD, m);
         rd(MD, m);
         check({6'h00, xt}, {6'h00, m[3:2]});
         check({7'h00, adn}, {7'h00, m[5]});
      end
      req_on <= 1'b1;
      rd(CS, 8'h00);
      req_on <= 1'b0;
      rd(CS, 8'hf0);
      wr(cdsc_pkg::CDSC_OFS_CLEAR, m);
      rd(cdsc_pkg::CDSC_OFS_CLEAR, 8'h00);
      rd(MD, 8'h00);
      rd(MID, 8'h00);
      // top byte must be ignored while extended counting is off
      wr(cdsc_pkg::CDSC_OFS_COUNT_TOP, 8'h01);
      wr(LO, 8'h01);
      wr(MD, 8'h04);
      n_done = 0;
      slow <= 1'b1;
      req_on <= 1'b1;
      wait_go(1'b1);
      wait_go(1'b0);
      check(n_done[7:0], 8'h02);
      check({7'h00, tc}, 8'h01);
      rd(CS, 8'h0f);
      rd(MK, 8'h01);
      go_idle(5);
      wr(CS, 8'h04);
      wr(MK, 8'h00);
      go_idle(5);
      wr(cdsc_pkg::CDSC_OFS_CLEAR, 8'h00);
      req_on <= 1'b0;
      slow <= 1'b0;
      wr(LO, 8'h02);
      wr(MD, 8'h10);
      wr(cdsc_pkg::CDSC_OFS_SW_REQ, 8'h04);
      go_idle(5);
      wr(MD, 8'h90);
      n_done = 0;
      wr(cdsc_pkg::CDSC_OFS_SW_REQ, 8'h04);
      wait_go(1'b1);
      wait_go(1'b0);
      check(n_done[7:0], 8'h03);
      rd(MK, 8'h00);
      rd(LO, 8'h02);
      // cascade request mode must never start a run
      wr(MD, 8'hc0);
      req_on <= 1'b1;
      go_idle(3);
      req_on <= 1'b0;
      // extended count: top byte keeps a zero low word from raising terminal count
      wr(cdsc_pkg::CDSC_OFS_CLEAR, 8'h00);
      cfg <= 8'h08;
      wr(cdsc_pkg::CDSC_OFS_COUNT_TOP, 8'h01);
      wr(MD, 8'h40);
      n_done = 0;
      req_on <= 1'b1;
      wait_go(1'b1);
      req_on <= 1'b0;
      wait_go(1'b0);
      check(n_done[7:0], 8'h01);
      check({7'h00, tc}, 8'h00);
      rd(MK, 8'h00);
      rd(MID, 8'hff);
      rd(cdsc_pkg::CDSC_OFS_COUNT_TOP, 8'h00);
      repeat (3) @(negedge clk_sys_i);
      final_report();
   end
   initial begin
      repeat (20000) @(posedge clk_sys_i);
      bad_count++;
      final_report();
   end
endmodule
`default_nettype wire
